/* File: hdl/tcoc_timer.sv */
/*
  16-bit timer with two compare channels, normal and clear-on-match modes.
  assumes a prescaler outside gives a one-cycle timer tick on i_clk.
*/
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module tcoc_timer
  import tcoc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // prescaled timer clock enable
  input wire logic i_timer_tick,
  // compare output pins, index 0 is channel a
  input wire logic [1:0] i_cmp_pin,
  output logic [1:0] o_cmp_pin,
  output logic [1:0] o_cmp_pin_oe
);
  ////////////////////////////////////////////////////////////////////////
  // declarations

  tcoc_req_if req (); // bus request carrier
  tcoc_chan_if chan [2] (); // per-channel carriers

  logic [3:0] waveform_mode_select; // counting sequence select
  logic [1:0] compare_output_mode_field [2]; // output action per channel
  logic [15:0] timer_count_value; // the counter
  logic [15:0] compare_value_reg [2]; // compare a and b
  logic [15:0] capture_value_reg; // capture register, top in mode 12
  logic overflow_flag; // sticky overflow
  logic [1:0] compare_match_flag; // sticky compare flags
  logic capture_flag; // sticky capture flag
  logic [1:0] output_pin_direction_bit; // pin directions
  logic [1:0] port_out_val; // general port output values
  logic [2:0] pin_sync [2]; // three-stage pin input sync
  logic [1:0] pin_in; // filtered pin input level
  logic block_match; // matches suppressed until next tick
  logic [1:0] hit; // qualified matches from channels
  logic [1:0] state; // output states from channels
  logic [1:0] force_strobe; // force request, mode gated
  logic wr_ctrl; // control register write
  logic wr_count; // counter write
  logic wr_flags; // flag register write
  logic mode_ctc; // any clear-on-match mode
  logic [15:0] top_value; // current top in clear mode
  logic top_hit; // top match on a tick
  logic wrap; // count passes max to zero
  logic [31:0] next_rdata; // read mux value

  ////////////////////////////////////////////////////////////////////////
  // bus front end

  tcoc_bus_slave u_bus (
    .i_clk (i_clk),
    .i_rst_b (i_rst_b),
    .i_wb_cyc (i_wb_cyc),
    .i_wb_stb (i_wb_stb),
    .i_wb_we (i_wb_we),
    .i_wb_adr (i_wb_adr),
    .i_wb_sel (i_wb_sel),
    .i_wb_dat (i_wb_dat),
    .o_wb_dat (o_wb_dat),
    .o_wb_ack (o_wb_ack),
    .req (req.bus)
  );

  // write decodes
  assign wr_ctrl = req.wr && (req.idx == IDX_CTRL);
  assign wr_count = req.wr && (req.idx == IDX_COUNT);
  assign wr_flags = req.wr && (req.idx == IDX_FLAGS);

  ////////////////////////////////////////////////////////////////////////
  // compare channels

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_chan
      assign chan[g].count = timer_count_value;
      assign chan[g].compare = compare_value_reg[g];
      assign chan[g].com = compare_output_mode_field[g];
      assign chan[g].tick = i_timer_tick;
      assign chan[g].block = block_match;
      assign chan[g].force_cmp = force_strobe[g];
      assign chan[g].dir = output_pin_direction_bit[g];
      assign chan[g].port_val = port_out_val[g];
      assign hit[g] = chan[g].hit;
      assign state[g] = chan[g].state;
      assign o_cmp_pin[g] = chan[g].pin;
      assign o_cmp_pin_oe[g] = chan[g].oe;

      tcoc_cmp_chan u_chan (
        .i_clk (i_clk),
        .i_rst_b (i_rst_b),
        .ch (chan[g].chan)
      );

      // force lasts the single write cycle, pwm modes ignore it
      assign force_strobe[g] = wr_ctrl && req.sel[1] &&
                               req.wdata[CTRL_FORCE_LSB + g] &&
                               tcoc_non_pwm(req.wdata[CTRL_WGM_LSB +: 4]);

      // compare values, written straight through in these modes
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          compare_value_reg[g] <= CNT_RST;
        end
        else if (req.wr && (req.idx == IDX_CMP_A + 6'(g)))
        begin
          compare_value_reg[g] <= tcoc_merge16(compare_value_reg[g], req.wdata, req.sel);
        end
      end

      // pin input sync; a level counts once stages two and three agree
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          pin_sync[g] <= 3'h0;
          pin_in[g] <= 1'b0;
        end
        else
        begin
          pin_sync[g] <= {pin_sync[g][1:0], i_cmp_pin[g]};
          if (pin_sync[g][1] == pin_sync[g][2])
          begin
            pin_in[g] <= pin_sync[g][2];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // control register: mode and output mode fields

  // the output state is not reset here, so mode changes keep it
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      waveform_mode_select <= WGM_RST;
      compare_output_mode_field[0] <= TCOC_COM_OFF;
      compare_output_mode_field[1] <= TCOC_COM_OFF;
    end
    else if (wr_ctrl && req.sel[0])
    begin
      waveform_mode_select <= req.wdata[CTRL_WGM_LSB +: 4];
      compare_output_mode_field[0] <= req.wdata[CTRL_COM_LSB +: 2];
      compare_output_mode_field[1] <= req.wdata[CTRL_COM_LSB + 2 +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture register, written by software only in this block

  // capture events are outside this block; the mode field never reaches here
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      capture_value_reg <= CNT_RST;
    end
    else if (req.wr && (req.idx == IDX_CAPT))
    begin
      capture_value_reg <= tcoc_merge16(capture_value_reg, req.wdata, req.sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // top selection for clear-on-match

  assign mode_ctc = (waveform_mode_select == TCOC_WGM_CTC_CMP) ||
                    (waveform_mode_select == TCOC_WGM_CTC_CAP);
  // unbuffered: a top rewritten below the count is simply passed by
  assign top_value = (waveform_mode_select == TCOC_WGM_CTC_CAP) ?
                     capture_value_reg : compare_value_reg[0];
  // a blocked top match does not clear, so counting runs on to max
  assign top_hit = mode_ctc && i_timer_tick && !block_match &&
                   (timer_count_value == top_value);
  assign wrap = i_timer_tick && !wr_count && (timer_count_value == CNT_MAX);

  ////////////////////////////////////////////////////////////////////////
  // counter

  // a bus write wins over the tick in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      timer_count_value <= CNT_RST;
    end
    else if (wr_count)
    begin
      timer_count_value <= tcoc_merge16(timer_count_value, req.wdata, req.sel);
    end
    else if (i_timer_tick)
    begin
      if (top_hit)
      begin
        timer_count_value <= CNT_RST;
      end
      else
      begin
        timer_count_value <= timer_count_value + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // match blocking after a counter write

  // holds through a stopped timer until the next tick passes
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      block_match <= 1'b0;
    end
    else if (wr_count)
    begin
      block_match <= 1'b1;
    end
    else if (i_timer_tick)
    begin
      block_match <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: hardware sets, software writes one to clear, set wins

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      overflow_flag <= 1'b0;
      compare_match_flag <= 2'h0;
      capture_flag <= 1'b0;
    end
    else
    begin
      if (wrap)
      begin
        overflow_flag <= 1'b1;
      end
      else if (wr_flags && req.sel[0] && req.wdata[FLG_OVF])
      begin
        overflow_flag <= 1'b0;
      end
      for (int i = 0; i < 2; i++)
      begin
        if (hit[i])
        begin
          compare_match_flag[i] <= 1'b1;
        end
        else if (wr_flags && req.sel[0] && req.wdata[FLG_CMP_LSB + i])
        begin
          compare_match_flag[i] <= 1'b0;
        end
      end
      if (top_hit && (waveform_mode_select == TCOC_WGM_CTC_CAP))
      begin
        capture_flag <= 1'b1;
      end
      else if (wr_flags && req.sel[0] && req.wdata[FLG_CAPT])
      begin
        capture_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port register: pin directions and general port values

  // software should set the output state before turning the pin on
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      output_pin_direction_bit <= 2'h0;
      port_out_val <= 2'h0;
    end
    else if (req.wr && (req.idx == IDX_PORT) && req.sel[0])
    begin
      output_pin_direction_bit <= req.wdata[PRT_DIR_LSB +: 2];
      port_out_val <= req.wdata[PRT_VAL_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, unmapped words read zero

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (req.idx)
      IDX_CTRL:
      begin
        next_rdata[CTRL_WGM_LSB +: 4] = waveform_mode_select;
        next_rdata[CTRL_COM_LSB +: 2] = compare_output_mode_field[0];
        next_rdata[CTRL_COM_LSB + 2 +: 2] = compare_output_mode_field[1];
      end
      IDX_COUNT: next_rdata[15:0] = timer_count_value;
      IDX_CMP_A: next_rdata[15:0] = compare_value_reg[0];
      IDX_CMP_B: next_rdata[15:0] = compare_value_reg[1];
      IDX_CAPT: next_rdata[15:0] = capture_value_reg;
      IDX_FLAGS:
      begin
        next_rdata[FLG_OVF] = overflow_flag;
        next_rdata[FLG_CMP_LSB +: 2] = compare_match_flag;
        next_rdata[FLG_CAPT] = capture_flag;
      end
      IDX_PORT:
      begin
        next_rdata[PRT_DIR_LSB +: 2] = output_pin_direction_bit;
        next_rdata[PRT_VAL_LSB +: 2] = port_out_val;
        next_rdata[PRT_IN_LSB +: 2] = pin_in;
      end
      IDX_STATE: next_rdata[1:0] = state;
      default: next_rdata = 32'h0000_0000; // unmapped
    endcase
  end

  assign req.rdata = next_rdata;
endmodule : tcoc_timer

/* File: shared/tcoc_pkg.sv */
/*
  constants, types and helper functions shared by the timer compare block.
  assumes a 32-bit classic wishbone bus with word-aligned registers.
*/
package tcoc_pkg;
  // counter geometry
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // register word indexes (byte address / 4)
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_COUNT = 6'h01;
  localparam logic [5:0] IDX_CMP_A = 6'h02;
  localparam logic [5:0] IDX_CMP_B = 6'h03;
  localparam logic [5:0] IDX_CAPT = 6'h04;
  localparam logic [5:0] IDX_FLAGS = 6'h05;
  localparam logic [5:0] IDX_PORT = 6'h06;
  localparam logic [5:0] IDX_STATE = 6'h07;
  // control field positions
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COM_LSB = 4;
  localparam int CTRL_FORCE_LSB = 8;
  // flag positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP_LSB = 1;
  localparam int FLG_CAPT = 3;
  // port register positions
  localparam int PRT_DIR_LSB = 0;
  localparam int PRT_VAL_LSB = 2;
  localparam int PRT_IN_LSB = 4;
  localparam logic [3:0] WGM_RST = 4'h0;
  // waveform modes handled here
  typedef enum logic [3:0] {
    TCOC_WGM_NORMAL = 4'h0,
    TCOC_WGM_CTC_CMP = 4'h4,
    TCOC_WGM_CTC_CAP = 4'hc
  } tcoc_wgm_type;
  // non-pwm output actions
  typedef enum logic [1:0] {
    TCOC_COM_OFF = 2'h0,
    TCOC_COM_TOGGLE = 2'h1,
    TCOC_COM_CLEAR = 2'h2,
    TCOC_COM_SET = 2'h3
  } tcoc_com_type;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] tcoc_merge16(input logic [15:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0] sel);
    tcoc_merge16 = {sel[1] ? wdata[15:8] : old[15:8], sel[0] ? wdata[7:0] : old[7:0]};
  endfunction : tcoc_merge16

  // true for modes that are not pwm
  function automatic logic tcoc_non_pwm(input logic [3:0] wgm);
    tcoc_non_pwm = (wgm == TCOC_WGM_NORMAL) || (wgm == TCOC_WGM_CTC_CMP) ||
                   (wgm == TCOC_WGM_CTC_CAP) || (wgm == 4'hd);
  endfunction : tcoc_non_pwm
endpackage : tcoc_pkg

/* File: shared/tcoc_if.sv */
/*
  carriers between the core and its helper modules.
  assumes all parties sit on the one system clock.
*/
`timescale 1ns/1ps
// one compare channel
interface tcoc_chan_if;
  logic [15:0] count; // live counter
  logic [15:0] compare; // compare value
  logic [1:0] com; // output mode field
  logic tick; // timer clock enable
  logic block; // match suppression
  logic force_cmp; // force strobe, already gated by mode
  logic dir; // pin direction bit
  logic port_val; // general port value
  logic hit; // qualified match
  logic state; // internal output state
  logic pin; // pin level
  logic oe; // pin drive enable
  modport core (output count, compare, com, tick, block, force_cmp, dir, port_val,
                input hit, state, pin, oe);
  modport chan (input count, compare, com, tick, block, force_cmp, dir, port_val,
                output hit, state, pin, oe);
endinterface : tcoc_chan_if

// register request from the bus front end
interface tcoc_req_if;
  logic wr; // write commits this edge
  logic [5:0] idx; // word index
  logic [31:0] wdata; // write data
  logic [3:0] sel; // byte lanes
  logic [31:0] rdata; // read value of idx
  modport bus (output wr, idx, wdata, sel, input rdata);
  modport core (input wr, idx, wdata, sel, output rdata);
endinterface : tcoc_req_if

/* File: hdl/tcoc_bus_slave.sv */
/*
  classic wishbone slave front end: one ack per request, registered data.
  assumes the master holds its request until it samples ack.
*/
`timescale 1ns/1ps
module tcoc_bus_slave
  import tcoc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // wishbone
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // core side
  tcoc_req_if.bus req
);
  logic take; // request taken at this edge

  // the guard on ack keeps a held request from being taken twice
  assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign req.wr = take & i_wb_we;
  assign req.idx = i_wb_adr[7:2];
  assign req.wdata = i_wb_dat;
  assign req.sel = i_wb_sel;

  ////////////////////////////////////////////////////////////////////////
  // ack and read data
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= take;
      if (take && !i_wb_we)
      begin
        o_wb_dat <= req.rdata; // sampled with the ack
      end
    end
  end
endmodule : tcoc_bus_slave

/* File: hdl/tcoc_cmp_chan.sv */
/*
  one compare channel: comparator, output state and pin override.
  assumes tick, block and force come from the core on the same clock.
*/
`timescale 1ns/1ps
module tcoc_cmp_chan
  import tcoc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // core side
  tcoc_chan_if.chan ch
);
  logic act; // apply the output action now
  logic next_state; // state after the action

  // a match only counts on a timer tick and when not blocked
  assign ch.hit = ch.tick & ~ch.block & (ch.count == ch.compare);
  assign act = ch.hit | ch.force_cmp;

  // action picked from the live mode field, no shadow copy
  always_comb
  begin
    unique case (tcoc_com_type'(ch.com))
      TCOC_COM_OFF: next_state = ch.state;
      TCOC_COM_TOGGLE: next_state = ~ch.state;
      TCOC_COM_CLEAR: next_state = 1'b0;
      TCOC_COM_SET: next_state = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // internal output state, untouched by mode changes
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ch.state <= 1'b0;
    end
    else if (act)
    begin
      ch.state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin level and enable, registered for clean outputs
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ch.pin <= 1'b0;
      ch.oe <= 1'b0;
    end
    else
    begin
      ch.pin <= (ch.com != 2'h0) ? ch.state : ch.port_val;
      ch.oe <= ch.dir;
    end
  end
endmodule : tcoc_cmp_chan

/* File: testbench/tcoc_timer_asserts.sv */
/*
  port checker for the timer compare block.
  assumes it is bound to tcoc_timer and sees classic wishbone cycles.
*/
`timescale 1ns/1ps
module tcoc_timer_asserts
  import tcoc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // wishbone
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // timer and pins
  input wire logic i_timer_tick,
  input wire logic [1:0] i_cmp_pin,
  input wire logic [1:0] o_cmp_pin,
  input wire logic [1:0] o_cmp_pin_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic take; // request taken at this edge
  logic wr_port; // port register write
  logic frc_a; // force strobe on channel a
  logic [1:0] com_a; // shadow of mode field a
  logic pv_a; // shadow of port value a
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_port = take && i_wb_we && i_wb_adr[7:2] == IDX_PORT && i_wb_sel[0];
  assign frc_a = take && i_wb_we && i_wb_adr[7:2] == IDX_CTRL && i_wb_sel[1] && i_wb_dat[8];
  ////////////////////////////////////////////////////////////////////////////////
  // shadows follow committed writes, so pin source can be predicted
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      com_a <= 2'h0;
      pv_a <= 1'b0;
    end
    else
    begin
      if (take && i_wb_we && i_wb_adr[7:2] == IDX_CTRL && i_wb_sel[0])
        com_a <= i_wb_dat[5:4];
      if (wr_port)
        pv_a <= i_wb_dat[2];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_answer: assert property (take |=> o_wb_ack) else $error("ack missing");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_unmapped_zero: assert property (take && !i_wb_we && i_wb_adr[7:2] > IDX_STATE |=>
    o_wb_dat == 32'h0) else $error("unmapped read not zero");
  a_oe_direction: assert property (wr_port |-> ##2 o_cmp_pin_oe == $past(i_wb_dat[1:0], 2))
    else $error("drive enable differs from direction");
  a_oe_cause: assert property ($changed(o_cmp_pin_oe) |-> $past(wr_port, 2))
    else $error("drive enable moved without write");
  a_port_override: assert property ($past(com_a) == 2'h0 |-> o_cmp_pin[0] == $past(pv_a))
    else $error("pin not port value with mode off");
  a_pin_on_tick: assert property ($changed(o_cmp_pin[0]) && $past(com_a) != 2'h0 &&
    $past(com_a) == $past(com_a, 2) |-> $past(i_timer_tick, 2) || $past(frc_a, 2) ||
    $past(frc_a, 3)) else $error("output moved without tick or force");
endmodule : tcoc_timer_asserts

bind tcoc_timer tcoc_timer_asserts u_asserts (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_timer_tick(i_timer_tick), .i_cmp_pin(i_cmp_pin), .o_cmp_pin(o_cmp_pin),
  .o_cmp_pin_oe(o_cmp_pin_oe));

/* File: testbench/tb.sv */
/*
  self-checking bench for the timer compare block.
  assumes the bench alone drives the bus, the timer tick and the pin inputs.
*/
`timescale 1ns/1ps
module tb;
  import tcoc_pkg::*;
  typedef struct { logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e; } tcoc_row_type;
  logic clk = 1'b0, rst_b, cyc, stb, we, ack, tick;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r;
  logic [1:0] pin_in, pin, pin_oe;
  int num_errors = 0;
  int n_compared = 0;
  // address, data, lanes, read-back
  tcoc_row_type rows [8] = '{'{8'h08, 32'habcd1234, 4'h3, 32'h1234},
    '{8'h0c, 32'h5678, 4'h1, 32'h78}, '{8'h10, 32'hffff, 4'h3, 32'hffff},
    '{8'h04, 32'hbeef, 4'h3, 32'hbeef}, '{8'h18, 32'hf, 4'h1, 32'hf},
    '{8'h1c, 32'h3, 4'h1, 32'h0}, '{8'h20, 32'hff, 4'hf, 32'h0}, '{8'h14, 32'hf, 4'h1, 32'h0}};
  logic [2:0] frc [5] = '{3'b111, 3'b001, 3'b010, 3'b011, 3'b100}; // mode field, new state
  logic [3:0] md [2] = '{4'h4, 4'hc};
  logic [31:0] ef [2] = '{32'h2, 32'ha};
  int n;
  logic p;
  tcoc_timer u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_timer_tick(tick), .i_cmp_pin(pin_in), .o_cmp_pin(pin),
    .o_cmp_pin_oe(pin_oe));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle, entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    r = rdat;
    if (k >= 20)
    begin
      num_errors++;
      $display("BAD %0t no ack", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 4'h3);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, 4'hf);
    chk(r, e);
  endtask : rd
  // tick held for k edges
  task automatic ticks(input int k);
    tick <= 1'b1;
    repeat (k) @(posedge clk);
    tick <= 1'b0;
  endtask : ticks
  // look at pins away from the edge, {oe, level}
  task automatic peek(input logic [3:0] e);
    @(negedge clk);
    chk({28'h0, pin_oe, pin}, {28'h0, e});
    @(posedge clk);
  endtask : peek
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial
  begin
    {rst_b, cyc, stb, we, tick, adr, sel, wdat, pin_in} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(8'h1c, 32'h0);
    foreach (rows[i])
    begin
      bus(rows[i].a, 1'b1, rows[i].d, rows[i].s);
      rd(rows[i].a, rows[i].e);
    end
    // wrap in normal mode, flag only when count becomes zero
    wr(8'h04, 32'hfffe);
    ticks(1);
    rd(8'h14, 32'h0);
    ticks(1);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h1);
    // counter write hides a match on the next tick only
    wr(8'h14, 32'hf);
    wr(8'h08, 32'h10);
    wr(8'h04, 32'h10);
    ticks(1);
    rd(8'h14, 32'h0);
    rd(8'h04, 32'h11);
    wr(8'h04, 32'hf);
    ticks(2);
    rd(8'h14, 32'h2);
    // forced compare walks every output action
    wr(8'h14, 32'hf);
    foreach (frc[i])
    begin
      // the force acts on the stored mode field, so store it first
      wr(8'h00, {26'h0, frc[i][2:1], 4'h0});
      wr(8'h00, {23'h0, 1'b1, 2'h0, frc[i][2:1], 4'h0});
      rd(8'h1c, {31'h0, frc[i][0]});
    end
    rd(8'h14, 32'h0);
    rd(8'h04, 32'h11);
    // pin source and drive enable
    pin_in <= 2'b10;
    wr(8'h00, 32'h30);
    wr(8'h00, 32'h130);
    wr(8'h18, 32'h1);
    peek(4'h5);
    wr(8'h00, 32'h4);
    peek(4'h4);
    wr(8'h00, 32'h0);
    rd(8'h1c, 32'h1);
    wr(8'h18, 32'h0);
    peek(4'h0);
    rd(8'h18, 32'h20);
    // both clear-on-match top sources
    foreach (md[i])
    begin
      wr(8'h00, {28'h0, md[i]});
      wr(8'h08, 32'h5);
      wr(8'h10, 32'h5);
      wr(8'h04, 32'h0);
      wr(8'h14, 32'hf);
      ticks(7);
      rd(8'h04, 32'h1);
      rd(8'h14, ef[i]);
      // count written equal to top: that match is skipped, counting runs on
      wr(8'h04, 32'h5);
      ticks(1);
      rd(8'h04, 32'h6);
    end
    // count above top runs through max, overflow on the wrap
    wr(8'h00, 32'h4);
    wr(8'h04, 32'hfff0);
    wr(8'h14, 32'hf);
    ticks(16);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h1);
    // toggle period is one plus top ticks
    wr(8'h00, 32'h14);
    wr(8'h08, 32'h3);
    wr(8'h18, 32'h1);
    tick <= 1'b1;
    repeat (2)
    begin
      n = 0;
      p = pin[0];
      while (pin[0] === p && n < 50)
      begin
        @(posedge clk);
        n++;
      end
    end
    chk(32'(n), 32'h4);
    tick <= 1'b0;
    // reset in mid-run clears the output state
    wr(8'h00, 32'h30);
    wr(8'h00, 32'h130);
    rd(8'h1c, 32'h1);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(8'h1c, 32'h0);
    peek(4'h0);
    complete_run();
  end
endmodule : tb
